// ===== inc/acd_pkg.sv
// constants shared by the angle calibration datapath
package acd_pkg;

   // register word addresses
   localparam logic [15:0] ACD_ADDR_ANGLE      = 16'h0002;
   localparam logic [15:0] ACD_ADDR_ZERO       = 16'h00A0;
   localparam logic [15:0] ACD_ADDR_TABLE_LO   = 16'h00B0;
   localparam logic [15:0] ACD_ADDR_TABLE_HI   = 16'h00EE;
   localparam logic [15:0] ACD_ADDR_CHECKSUM   = 16'h00F0;
   localparam logic [15:0] ACD_ADDR_CUST_LO    = 16'h00F2;
   localparam logic [15:0] ACD_ADDR_CUST_HI    = 16'h00FE;

   // sizes
   localparam int          ACD_TABLE_ENTRIES   = 32;
   localparam int          ACD_CUST_WORDS      = 7;
   localparam logic [4:0]  ACD_TABLE_LAST_IDX  = 5'h1F;

   // field positions
   localparam int          ACD_ZERO_OFS_MSB    = 15;
   localparam int          ACD_ZERO_OFS_LSB    = 2;
   localparam int          ACD_ZERO_DIR_BIT    = 1;
   localparam int          ACD_CRC_MSB         = 7;
   localparam int          ACD_ANGLE_MSB       = 14;

   // reset values
   localparam logic [15:0] ACD_ZERO_RESET      = 16'h0000;
   localparam logic [15:0] ACD_CHECKSUM_RESET  = 16'h0000;
   localparam logic [15:0] ACD_CUST_RESET      = 16'h0000;
   localparam logic [14:0] ACD_ANGLE_RESET     = 15'h0000;

   // crc engine, polynomial x^8+x^4+x^3+x^2+1
   localparam logic [7:0]  ACD_CRC_POLY        = 8'h1D;
   localparam logic [7:0]  ACD_CRC_INIT        = 8'hFF;

   // reduced output range
   localparam logic [11:0] ACD_RED_SPAN        = 12'hFF8;
   localparam logic [11:0] ACD_RED_MIN         = 12'h001;

   // checksum scan states, gray along the path
   typedef enum logic [1:0] {
      ACD_SCAN_IDLE = 2'b00,
      ACD_SCAN_RUN  = 2'b01,
      ACD_SCAN_DONE = 2'b11
   } acd_scan_t;

endpackage

// ===== design/acd_crc8.sv
// 8-bit crc engine consuming one 16-bit word per step
`timescale 1ns/10ps
module acd_crc8
   import acd_pkg::*;
(
   // clock and reset
   input  wire logic        clk,
   input  wire logic        reset,
   // control
   input  wire logic        clear,
   input  wire logic        step,
   input  wire logic [15:0] data,
   // result
   output logic      [7:0]  crc
);

   logic [7:0] next_crc;

   // msb first, sixteen bits per step
   always_comb begin
      next_crc = crc;
      for (int b = 15; b >= 0; b--) begin
         if (next_crc[7] ^ data[b]) begin
            next_crc = {next_crc[6:0], 1'b0} ^ ACD_CRC_POLY;
         end else begin
            next_crc = {next_crc[6:0], 1'b0};
         end
      end
   end

   always_ff @(posedge clk) begin
      if (reset || clear) begin
         crc <= ACD_CRC_INIT;
      end else if (step) begin
         crc <= next_crc;
      end
   end

endmodule

// ===== design/acd_datapath.sv
// angle calibration datapath: registers, table, checksum scan, output scaling
//
// Summary of operation
// - angle register holds raw 15-bit two's complement angle in bits 14:0
// - normal output code is unsigned 12 bits, 0 to 4095, zero means zero degrees
// - reduced range maps a full turn onto codes 1 to 4088
// - zero-angle word bits 15:2 hold 14-bit offset the output angle code refers to; the angle register reads back raw
// - zero-angle bit 1 selects direction: 0 counter-clockwise, 1 clockwise
// - 32-entry 16-bit linearization table, entry n at n times 11.25 degrees
// - 8-bit crc over all table entries sits in checksum bits 7:0
// - unused table holds ideal angles; parts start with those defaults
// - 112 bits of customer data kept in page 0x00F
// - with short messages on, first 32 customer bits are sent out
// - customer data words are not covered by any crc
// - table changed after the first scan from reset without matching checksum raises crc error
`timescale 1ns/10ps
module acd_datapath
   import acd_pkg::*;
(
   // clock and reset
   input  wire logic        clk,
   input  wire logic        reset,
   // raw angle from the sensor front end
   input  wire logic [14:0] raw_angle,
   input  wire logic        raw_valid,
   // mode straps
   input  wire logic        reduced_range,
   input  wire logic        ssm_enable,
   // register port behind the single wire config port
   input  wire logic [15:0] reg_addr,
   input  wire logic        reg_wr,
   input  wire logic        reg_rd,
   input  wire logic [15:0] reg_wdata,
   output logic      [15:0] reg_rdata,
   output logic             reg_rvalid,
   // output angle code
   output logic      [11:0] angle_code,
   output logic             code_valid,
   // short serial message payload
   output logic      [31:0] ssm_data,
   output logic             ssm_valid,
   // integrity
   output logic             crc_error
);

   ////////////////////////////////////////////////////////////////////////////
   // storage

   logic      [14:0] angle_reading;
   logic      [15:0] zero_angle_word;
   logic      [15:0] table_checksum;
   logic      [15:0] lut [ACD_TABLE_ENTRIES];
   logic      [15:0] cust [ACD_CUST_WORDS];

   ////////////////////////////////////////////////////////////////////////////
   // address decode

   wire              hit_angle    = (reg_addr == ACD_ADDR_ANGLE);
   wire              hit_zero     = (reg_addr == ACD_ADDR_ZERO);
   wire              hit_checksum = (reg_addr == ACD_ADDR_CHECKSUM);
   wire              hit_table    = (reg_addr >= ACD_ADDR_TABLE_LO) && (reg_addr <= ACD_ADDR_TABLE_HI)
                                    && !reg_addr[0];
   wire              hit_cust     = (reg_addr >= ACD_ADDR_CUST_LO) && (reg_addr <= ACD_ADDR_CUST_HI)
                                    && !reg_addr[0];
   wire       [15:0] table_ofs    = reg_addr - ACD_ADDR_TABLE_LO;
   wire       [4:0]  table_sel    = table_ofs[5:1];
   wire       [15:0] cust_ofs     = reg_addr - ACD_ADDR_CUST_LO;
   wire       [2:0]  cust_sel     = cust_ofs[3:1];
   wire              wr_table     = reg_wr && hit_table;
   wire              wr_checksum  = reg_wr && hit_checksum;
   wire              wr_zero      = reg_wr && hit_zero;

   logic      [15:0] rd_mux;
   always_comb begin
      if (hit_angle) begin
         rd_mux = {1'b0, angle_reading};
      end else if (hit_zero) begin
         rd_mux = zero_angle_word;
      end else if (hit_checksum) begin
         rd_mux = table_checksum;
      end else if (hit_table) begin
         rd_mux = lut[table_sel];
      end else if (hit_cust) begin
         rd_mux = cust[cust_sel];
      end else begin
         rd_mux = 16'h0000;
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         reg_rdata  <= 16'h0000;
         reg_rvalid <= 1'b0;
      end else begin
         reg_rvalid <= reg_rd;
         if (reg_rd) begin
            reg_rdata <= rd_mux;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // configuration words; bit 0 of zero word stored but never used

   always_ff @(posedge clk) begin
      if (reset) begin
         zero_angle_word <= ACD_ZERO_RESET;
      end else if (wr_zero) begin
         zero_angle_word <= reg_wdata;
      end
   end

   // table entries start at ideal angles n*2048
   genvar gi;
   generate
      for (gi = 0; gi < ACD_TABLE_ENTRIES; gi++) begin : g_lut
         always_ff @(posedge clk) begin
            if (reset) begin
               lut[gi] <= {5'(gi), 11'h000};
            end else if (wr_table && (table_sel == 5'(gi))) begin
               lut[gi] <= reg_wdata;
            end
         end
      end
      for (gi = 0; gi < ACD_CUST_WORDS; gi++) begin : g_cust
         always_ff @(posedge clk) begin
            if (reset) begin
               cust[gi] <= ACD_CUST_RESET;
            end else if (reg_wr && hit_cust && (cust_sel == 3'(gi))) begin
               cust[gi] <= reg_wdata;
            end
         end
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////////
   // checksum scan over the table; customer words never enter it

   acd_scan_t        scan_state;
   logic      [4:0]  scan_idx;
   logic             first_scan;
   logic      [7:0]  crc_value;
   wire              scan_restart = wr_table || wr_checksum;
   wire              scan_step    = (scan_state == ACD_SCAN_RUN) && !scan_restart;

   acd_crc8 u_crc (
      .clk   (clk),
      .reset (reset),
      .clear (scan_restart || (scan_state == ACD_SCAN_IDLE)),
      .step  (scan_step),
      .data  (lut[scan_idx]),
      .crc   (crc_value)
   );

   always_ff @(posedge clk) begin
      if (reset) begin
         scan_state <= ACD_SCAN_IDLE;
         scan_idx   <= 5'h00;
      end else if (scan_restart) begin
         scan_state <= ACD_SCAN_RUN;
         scan_idx   <= 5'h00;
      end else begin
         case (scan_state)
            ACD_SCAN_IDLE: begin
               scan_state <= ACD_SCAN_RUN;
               scan_idx   <= 5'h00;
            end
            ACD_SCAN_RUN: begin
               scan_idx <= scan_idx + 5'h01;
               if (scan_idx == ACD_TABLE_LAST_IDX) begin
                  scan_state <= ACD_SCAN_DONE;
               end
            end
            default: begin
               scan_state <= ACD_SCAN_DONE;
            end
         endcase
      end
   end

   // first scan after reset seals the default table as consistent
   always_ff @(posedge clk) begin
      if (reset) begin
         table_checksum <= ACD_CHECKSUM_RESET;
         first_scan     <= 1'b1;
         crc_error      <= 1'b0;
      end else if (wr_checksum) begin
         table_checksum <= reg_wdata;
         first_scan     <= 1'b0;
      end else if ((scan_state == ACD_SCAN_DONE) && first_scan) begin
         table_checksum[ACD_CRC_MSB:0] <= crc_value;
         first_scan                    <= 1'b0;
         crc_error                     <= 1'b0;
      end else if (scan_state == ACD_SCAN_DONE) begin
         crc_error <= (crc_value != table_checksum[ACD_CRC_MSB:0]);
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // stage 1: offset and direction

   wire       [15:0] raw16      = {raw_angle, 1'b0};
   wire       [15:0] offset16   = {zero_angle_word[ACD_ZERO_OFS_MSB:ACD_ZERO_OFS_LSB], 2'b00};
   wire       [15:0] rel16      = raw16 - offset16;
   wire       [15:0] dir16      = zero_angle_word[ACD_ZERO_DIR_BIT] ? (16'h0000 - rel16) : rel16;
   logic      [15:0] s1_angle;
   logic             s1_valid;

   always_ff @(posedge clk) begin
      if (reset) begin
         angle_reading <= ACD_ANGLE_RESET;
         s1_angle      <= 16'h0000;
         s1_valid      <= 1'b0;
      end else begin
         s1_valid <= raw_valid;
         if (raw_valid) begin
            angle_reading <= raw_angle;
            s1_angle      <= dir16;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // stage 2: table correction interpolated between neighbour points

   wire       [4:0]  lin_idx    = s1_angle[15:11];
   wire       [4:0]  lin_idx_n  = lin_idx + 5'h01;
   wire       [10:0] lin_frac   = s1_angle[10:0];
   wire       [15:0] corr0      = lut[lin_idx] - {lin_idx, 11'h000};
   wire       [15:0] corr1      = lut[lin_idx_n] - {lin_idx_n, 11'h000};
   wire signed [16:0] corr_delta = $signed({corr1[15], corr1}) - $signed({corr0[15], corr0});
   wire signed [28:0] corr_prod  = corr_delta * $signed({1'b0, lin_frac});
   wire       [15:0] corr_step  = corr_prod[26:11];
   logic      [15:0] s2_angle;
   logic             s2_valid;

   always_ff @(posedge clk) begin
      if (reset) begin
         s2_angle <= 16'h0000;
         s2_valid <= 1'b0;
      end else begin
         s2_valid <= s1_valid;
         if (s1_valid) begin
            s2_angle <= s1_angle + corr0 + corr_step;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // stage 3: output scaling and short message payload

   wire       [27:0] red_prod   = s2_angle * ACD_RED_SPAN;
   wire       [11:0] red_code   = red_prod[27:16] + ACD_RED_MIN;
   wire       [11:0] full_code  = s2_angle[15:4];

   always_ff @(posedge clk) begin
      if (reset) begin
         angle_code <= 12'h000;
         code_valid <= 1'b0;
         ssm_data   <= 32'h0000_0000;
         ssm_valid  <= 1'b0;
      end else begin
         code_valid <= s2_valid;
         if (s2_valid) begin
            angle_code <= reduced_range ? red_code : full_code;
         end
         ssm_valid <= ssm_enable;
         ssm_data  <= ssm_enable ? {cust[0], cust[1]} : 32'h0000_0000;
      end
   end

endmodule

// ===== bench/acd_ctrl_model.sv
// controller model: register port driver and calibration word math
`timescale 1ns/10ps
module acd_ctrl_model
   import acd_pkg::*;
(
   // clock
   input  wire logic        clk,
   // register port
   output logic      [15:0] reg_addr,
   output logic             reg_wr,
   output logic             reg_rd,
   output logic      [15:0] reg_wdata,
   input  wire logic [15:0] reg_rdata,
   input  wire logic        reg_rvalid
);
   initial begin
      reg_addr  = 16'h0000;
      reg_wr    = 1'b0;
      reg_rd    = 1'b0;
      reg_wdata = 16'h0000;
   end
   task automatic wr(input logic [15:0] a, input logic [15:0] v);
      @(negedge clk);
      reg_addr  = a;
      reg_wdata = v;
      reg_wr    = 1'b1;
      @(negedge clk);
      reg_wr    = 1'b0;
      reg_wdata = ~v;
   endtask
   task automatic rd(input logic [15:0] a, output logic [15:0] v, output logic ok);
      @(negedge clk);
      reg_addr = a;
      reg_rd   = 1'b1;
      @(negedge clk);
      reg_rd = 1'b0;
      ok     = reg_rvalid;
      v      = reg_rdata;
   endtask
   function automatic logic [15:0] zword(input int code, input logic cw);
      int v;
      v = ((code - 1) * 32768 + 4088) / 8176;
      return {v[13:0], cw, 1'b0};
   endfunction
   function automatic logic [15:0] lut(input int n, input int rd12);
      int v;
      v = 4096 * n - 16 * rd12;
      return v[15:0];
   endfunction
   function automatic logic [7:0] crc(input logic [15:0] t[32]);
      logic [7:0] c;
      c = ACD_CRC_INIT;
      for (int n = 0; n < 32; n++) begin
         for (int b = 15; b >= 0; b--) begin
            c = {c[6:0], 1'b0} ^ ((c[7] ^ t[n][b]) ? ACD_CRC_POLY : 8'h00);
         end
      end
      return c;
   endfunction
endmodule

// ===== bench/acd_datapath_monitor.sv
// port checker for the angle calibration datapath
`timescale 1ns/10ps
module acd_datapath_monitor
   import acd_pkg::*;
(
   // clock and reset
   input wire logic        clk,
   input wire logic        reset,
   // inputs
   input wire logic [14:0] raw_angle,
   input wire logic        raw_valid,
   input wire logic        reduced_range,
   input wire logic        ssm_enable,
   input wire logic [15:0] reg_addr,
   input wire logic        reg_wr,
   input wire logic        reg_rd,
   input wire logic [15:0] reg_wdata,
   // outputs
   input wire logic [15:0] reg_rdata,
   input wire logic        reg_rvalid,
   input wire logic [11:0] angle_code,
   input wire logic        code_valid,
   input wire logic [31:0] ssm_data,
   input wire logic        ssm_valid,
   input wire logic        crc_error
);
   default clocking @(posedge clk); endclocking
   default disable iff (reset);
   wire tbl_wr = reg_wr && !reg_addr[0] && reg_addr >= ACD_ADDR_TABLE_LO && reg_addr <= ACD_ADDR_CHECKSUM;
   read_answer_a: assert property (reg_rvalid == $past(reg_rd))
      else $error("read answer timing wrong");
   angle_sign_a: assert property (reg_rvalid && $past(reg_addr) == ACD_ADDR_ANGLE |-> !reg_rdata[15])
      else $error("angle word bit 15 set");
   code_latency_a: assert property (code_valid == $past(raw_valid, 3))
      else $error("code valid timing wrong");
   code_hold_a: assert property (!code_valid |-> $stable(angle_code))
      else $error("code moved without sample");
   reduced_span_a: assert property (code_valid && $past(reduced_range) |->
      angle_code >= ACD_RED_MIN && angle_code <= ACD_RED_SPAN)
      else $error("reduced code out of range");
   ssm_follow_a: assert property (ssm_valid == $past(ssm_enable))
      else $error("message valid timing wrong");
   ssm_quiet_a: assert property (!ssm_valid |-> ssm_data == 32'h0000_0000)
      else $error("message data while off");
   scan_hold_a: assert property (tbl_wr |=> ##1 $stable(crc_error) [*8])
      else $error("error flag moved during scan");
   cover property (code_valid && reduced_range);
   cover property ($rose(crc_error));
   cover property (ssm_valid);
endmodule
bind acd_datapath acd_datapath_monitor mon (.*);

// ===== bench/acd_datapath_tb.sv
// self-checking bench for the angle calibration datapath
`timescale 1ns/10ps
`define CK(g, e) begin n_compared++; if ((g) !== (e)) begin n_errors++; \
   $display("unexpected at %0t: got %h exp %h", $time, g, e); end end
module acd_datapath_tb import acd_pkg::*;;
   logic        clk;
   logic        reset;
   logic [14:0] raw_angle;
   logic        raw_valid;
   logic        reduced_range;
   logic        ssm_enable;
   logic [15:0] reg_addr;
   logic        reg_wr;
   logic        reg_rd;
   logic [15:0] reg_wdata;
   logic [15:0] reg_rdata;
   logic        reg_rvalid;
   logic [11:0] angle_code;
   logic        code_valid;
   logic [31:0] ssm_data;
   logic        ssm_valid;
   logic        crc_error;
   int          n_errors;
   int          n_compared;
   logic [31:0] s;
   logic [15:0] tbl[32];
   logic [15:0] cw[7];
   logic [15:0] d;
   logic [15:0] zw;
   logic        ok;
   acd_datapath uut (.*);
   acd_ctrl_model ctl (.*);
   function automatic logic [31:0] nx(input logic [31:0] v);
      return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
   endfunction
   function automatic logic [11:0] exp_code(input logic [14:0] r, input logic [15:0] z, input logic red);
      logic [15:0] a;
      logic [31:0] p;
      a = {r, 1'b0} - {z[15:2], 2'b00};
      if (z[1]) a = -a;
      p = a * 32'd4088;
      return red ? p[27:16] + 12'h001 : a[15:4];
   endfunction
   task automatic close_out();
      $display("compared %0d, mismatches %0d", n_compared, n_errors);
      if (n_errors == 0 && n_compared > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask
   task automatic ang(input logic [14:0] r);
      @(negedge clk);
      raw_angle = r;
      raw_valid = 1'b1;
      @(negedge clk);
      raw_valid = 1'b0;
      raw_angle = ~r;
      repeat (2) @(negedge clk);
      `CK(code_valid, 1'b1)
      `CK(angle_code, exp_code(r, zw, reduced_range))
      ctl.wr(ACD_ADDR_ANGLE, {1'b1, ~r});
      ctl.rd(ACD_ADDR_ANGLE, d, ok);
      `CK({ok, d}, {2'b10, r})
   endtask
   task automatic probe(input logic [14:0] r, input logic [11:0] e);
      @(negedge clk);
      raw_angle = r;
      raw_valid = 1'b1;
      @(negedge clk);
      raw_valid = 1'b0;
      repeat (2) @(negedge clk);
      `CK(angle_code, e)
   endtask
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   initial begin
      repeat (5000) @(posedge clk);
      n_errors++;
      close_out();
   end
   initial begin
      reset = 1'b1;
      raw_angle = 15'h0000;
      raw_valid = 1'b0;
      reduced_range = 1'b0;
      ssm_enable = 1'b0;
      n_errors = 0;
      n_compared = 0;
      s = 32'h6398_3b2a;
      zw = 16'h0000;
      repeat (4) @(negedge clk);
      reset = 1'b0;
      repeat (40) @(negedge clk);
      for (int n = 0; n < 32; n++) begin
         tbl[n] = 16'(n * 2048);
         ctl.rd(ACD_ADDR_TABLE_LO + 16'(2 * n), d, ok);
         `CK(d, tbl[n])
      end
      ctl.rd(ACD_ADDR_CHECKSUM, d, ok);
      `CK(d, {8'h00, ctl.crc(tbl)})
      ctl.rd(ACD_ADDR_ZERO, d, ok);
      `CK(d, 16'h0000)
      ctl.rd(16'h00A1, d, ok);
      `CK({ok, d}, 17'h1_0000)
      `CK(crc_error, 1'b0)
      $display("reset defaults done");
      for (int i = 0; i < 24; i++) begin
         s = nx(s);
         zw = (i < 3) ? 16'h0000 : ctl.zword(int'(s[27:16]) % 4088 + 1, s[28]);
         ctl.wr(ACD_ADDR_ZERO, zw);
         ctl.rd(ACD_ADDR_ZERO, d, ok);
         `CK(d, zw)
         reduced_range = (i == 0) ? 1'b0 : (i < 3) ? 1'b1 : s[29];
         ang((i == 0 || i == 2) ? 15'h0000 : (i == 1) ? 15'h7FFF : s[14:0]);
      end
      for (int i = 0; i < 6; i++) begin
         @(negedge clk);
         s = nx(s);
         raw_valid = 1'b1;
         raw_angle = s[14:0];
      end
      @(negedge clk);
      raw_valid = 1'b0;
      repeat (4) @(negedge clk);
      $display("angle path done");
      tbl[5] = ctl.lut(5, 650);
      ctl.wr(ACD_ADDR_TABLE_LO + 16'h000A, tbl[5]);
      repeat (36) @(negedge clk);
      `CK(crc_error, 1'b1)
      zw = 16'h0000;
      ctl.wr(ACD_ADDR_ZERO, zw);
      reduced_range = 1'b0;
      probe(15'h1400, tbl[5][15:4]);
      probe(15'h1200, 12'((tbl[4] + tbl[5]) >> 5));
      ctl.wr(ACD_ADDR_CHECKSUM, {8'h00, ctl.crc(tbl)});
      repeat (36) @(negedge clk);
      `CK(crc_error, 1'b0)
      tbl[5] = ctl.lut(5, 640);
      ctl.wr(ACD_ADDR_TABLE_LO + 16'h000A, tbl[5]);
      ctl.wr(ACD_ADDR_CHECKSUM, {8'h00, ctl.crc(tbl)});
      repeat (36) @(negedge clk);
      `CK(crc_error, 1'b0)
      $display("checksum done");
      ssm_enable = 1'b1;
      for (int k = 0; k < 7; k++) begin
         s = nx(s);
         cw[k] = s[15:0];
         ctl.wr(ACD_ADDR_CUST_LO + 16'(2 * k), cw[k]);
      end
      for (int k = 0; k < 7; k++) begin
         ctl.rd(ACD_ADDR_CUST_LO + 16'(2 * k), d, ok);
         `CK(d, cw[k])
      end
      `CK(ssm_valid, 1'b1)
      `CK(ssm_data, {cw[0], cw[1]})
      repeat (36) @(negedge clk);
      `CK(crc_error, 1'b0)
      ssm_enable = 1'b0;
      repeat (2) @(negedge clk);
      `CK(ssm_data, 32'h0000_0000)
      `CK(ssm_valid, 1'b0)
      $display("customer data done");
      close_out();
   end
endmodule
